// ### dtc_channel.sv
// One 16-bit timer/counter channel with gating and pin edge detection
`timescale 1ns/1ps
module dtc_channel
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Timing and configuration
    input  wire logic        pcyc_tick,
    input  wire logic        run_bit,
    input  wire logic        gating_enable,
    input  wire logic        source_select,
    // Pins
    input  wire logic        gate_pin,
    input  wire logic        count_pin,
    // Software preset
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [7:0]  wr_data,
    // Count and rollover
    output logic [7:0]       count_low_byte,
    output logic [7:0]       count_high_byte,
    output logic             overflow_pulse
);
    import dtc_pkg::*;

    logic sample_reg;
    logic enable;
    logic fall;
    logic inc;
    logic low_carry;

    assign enable    = run_bit && (!gating_enable || gate_pin);
    assign fall      = sample_reg && !count_pin;
    assign inc       = enable && pcyc_tick && (source_select ? fall : 1'b1);
    assign low_carry = inc && (count_low_byte == BYTE_ONES);

    // Pin is sampled once per peripheral cycle; an edge needs two samples
    always_ff @(posedge core_clk)
    begin
        if (rst)
            sample_reg <= 1'b0;
        else if (pcyc_tick)
            sample_reg <= count_pin;
    end

    // A preset write wins over its byte's concurrent increment, but a low write still carries into the high byte; writes while running are undefined anyway
    always_ff @(posedge core_clk)
    begin
        if (rst)
            count_low_byte <= CNT_RST;
        else if (wr_low)
            count_low_byte <= wr_data;
        else if (inc)
            count_low_byte <= count_low_byte + BYTE_ONE;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            count_high_byte <= CNT_RST;
        else if (wr_high)
            count_high_byte <= wr_data;
        else if (low_carry)
            count_high_byte <= count_high_byte + BYTE_ONE;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            overflow_pulse <= 1'b0;
        else
            overflow_pulse <= low_carry && (count_high_byte == BYTE_ONES) && !wr_high;
    end

    property p_cascade;
        @(posedge core_clk) disable iff (rst)
        (low_carry && !wr_low && !wr_high)
            |=> (count_low_byte == CNT_RST) && (count_high_byte == $past(count_high_byte) + BYTE_ONE);
    endproperty
    a_cascade: assert property (p_cascade) else $error("low byte carry not cascaded");

    property p_stopped;
        @(posedge core_clk) disable iff (rst)
        (!enable && !wr_low && !wr_high) |=> $stable({count_high_byte, count_low_byte});
    endproperty
    a_stopped: assert property (p_stopped) else $error("count moved while stopped or gated off");

    property p_edge_count;
        @(posedge core_clk) disable iff (rst)
        (enable && source_select && pcyc_tick && sample_reg && !count_pin && !wr_low)
            |=> count_low_byte == $past(count_low_byte) + BYTE_ONE;
    endproperty
    a_edge_count: assert property (p_edge_count) else $error("falling edge not counted");

    property p_start_keeps;
        @(posedge core_clk) disable iff (rst)
        ($rose(run_bit) && !pcyc_tick && !wr_low && !wr_high) |=> $stable({count_high_byte, count_low_byte});
    endproperty
    a_start_keeps: assert property (p_start_keeps) else $error("starting cleared the count");
endmodule // dtc_channel

// ### dtc_pin_model.sv
// Far-side model: external count sources and gate pins
`timescale 1ns/1ps
module dtc_pin_model
(
    // Clock
    input  wire logic  core_clk,
    // Pins seen by the block
    output logic [1:0] count_pin,
    output logic [1:0] gate_n
);
    initial
    begin
        count_pin = 2'b11;
        gate_n    = 2'b11;
    end

    task automatic set_gate(input int ch, input logic lvl);
        gate_n[ch] <= lvl;
        @(posedge core_clk);
    endtask

    // Each level stands hold clocks; callers keep hold at one peripheral cycle or more
    task automatic pulses(input int ch, input int n, input int hold);
        repeat (n)
        begin
            count_pin[ch] <= 1'b0;
            repeat (hold) @(posedge core_clk);
            count_pin[ch] <= 1'b1;
            repeat (hold) @(posedge core_clk);
        end
    endtask
endmodule // dtc_pin_model

// ### dtc_pkg.sv
// Shared constants for the dual 16-bit timer/counter block
package dtc_pkg;
    // Wishbone widths
    localparam int unsigned   WB_DAT_W     = 32;
    localparam int unsigned   WB_ADR_W     = 12;
    localparam int unsigned   WB_SEL_W     = 4;
    localparam int unsigned   IDX_W        = 10;
    localparam int unsigned   IDX_LSB      = 2;
    // Register indices; byte address is four times the index
    localparam logic [9:0]    IDX_CTRL     = 10'h088;
    localparam logic [9:0]    IDX_MODE     = 10'h089;
    localparam logic [9:0]    IDX_CNT0_LO  = 10'h08a;
    localparam logic [9:0]    IDX_CNT1_LO  = 10'h08b;
    localparam logic [9:0]    IDX_CNT0_HI  = 10'h08c;
    localparam logic [9:0]    IDX_CNT1_HI  = 10'h08d;
    localparam logic [9:0]    IDX_SPEED    = 10'h08e;
    // Control register fields
    localparam int unsigned   CTRL_IT0     = 0;
    localparam int unsigned   CTRL_IE0     = 1;
    localparam int unsigned   CTRL_IT1     = 2;
    localparam int unsigned   CTRL_IE1     = 3;
    localparam int unsigned   CTRL_RUN0    = 4;
    localparam int unsigned   CTRL_OVF0    = 5;
    localparam int unsigned   CTRL_RUN1    = 6;
    localparam int unsigned   CTRL_OVF1    = 7;
    // Mode nibble fields, one nibble per channel, and the speed register bit
    localparam int unsigned   NIB_W        = 4;
    localparam int unsigned   MODE_M_LO    = 0;
    localparam int unsigned   MODE_M_HI    = 1;
    localparam int unsigned   MODE_SRC     = 2;
    localparam int unsigned   MODE_GATE    = 3;
    localparam int unsigned   SPEED_X2     = 0;
    // Reset values and byte arithmetic constants
    localparam logic [7:0]    CTRL_RST     = 8'h00;
    localparam logic [7:0]    MODE_RST     = 8'h00;
    localparam logic [7:0]    CNT_RST      = 8'h00;
    localparam logic [7:0]    BYTE_ONES    = 8'hff;
    localparam logic [7:0]    BYTE_ONE     = 8'h01;
    // Peripheral cycle timing in core clocks (core clock is the oscillator)
    localparam int unsigned   PCLK_PER_PCYC    = 6;
    localparam int unsigned   OSC_PER_PCLK_STD = 2;
    localparam int unsigned   OSC_PER_PCLK_X2  = 1;
    localparam int unsigned   PRE_W            = 4;
    localparam logic [3:0]    PCYC_STD_LAST    = 4'(PCLK_PER_PCYC * OSC_PER_PCLK_STD - 1);
    localparam logic [3:0]    PCYC_X2_LAST     = 4'(PCLK_PER_PCYC * OSC_PER_PCLK_X2 - 1);
    localparam logic [3:0]    PRE_RST          = 4'h0;
    localparam logic [3:0]    PRE_ONE          = 4'h1;
endpackage

// ### dtc_prescaler.sv
// Peripheral cycle tick generator, standard or double-speed
`timescale 1ns/1ps
module dtc_prescaler
(
    // Clock and reset
    input  wire logic  core_clk,
    input  wire logic  rst,
    // Speed select and tick
    input  wire logic  double_speed_mode,
    output logic       pcyc_tick
);
    import dtc_pkg::*;

    logic [PRE_W-1:0] div_reg;
    logic [PRE_W-1:0] last_val;
    logic             mode_prev_reg;
    logic [PRE_W-1:0] mode_age_reg;
    logic [PRE_W-1:0] gap_reg;

    // Changing speed mid-cycle just shortens or stretches one cycle
    assign last_val = double_speed_mode ? PCYC_X2_LAST : PCYC_STD_LAST;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            div_reg   <= PRE_RST;
            pcyc_tick <= 1'b0;
        end
        else
        begin
            pcyc_tick <= (div_reg == last_val);
            div_reg   <= (div_reg >= last_val) ? PRE_RST : div_reg + PRE_ONE;
        end
    end

    // Checker helper: clocks since the last tick, counted from one so reset lines up with a tick
    always_ff @(posedge core_clk)
    begin
        if (rst)
            gap_reg <= PRE_RST;
        else if (pcyc_tick)
            gap_reg <= PRE_ONE;
        else if (!(&gap_reg))
            gap_reg <= gap_reg + PRE_ONE;
    end

    // Checker helper: clocks since the speed select last changed, so odd switch-over cycles are skipped
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mode_prev_reg <= 1'b0;
            mode_age_reg  <= PRE_RST;
        end
        else
        begin
            mode_prev_reg <= double_speed_mode;
            if (double_speed_mode != mode_prev_reg)
                mode_age_reg <= PRE_RST;
            else if (!(&mode_age_reg))
                mode_age_reg <= mode_age_reg + PRE_ONE;
        end
    end

    property p_tick_std;
        @(posedge core_clk) disable iff (rst)
        (pcyc_tick && !double_speed_mode && !mode_prev_reg && (mode_age_reg >= gap_reg - PRE_ONE))
            |-> gap_reg == PCYC_STD_LAST + PRE_ONE;
    endproperty
    a_tick_std: assert property (p_tick_std) else $error("standard tick spacing wrong");

    property p_tick_x2;
        @(posedge core_clk) disable iff (rst)
        (pcyc_tick && double_speed_mode && mode_prev_reg && (mode_age_reg >= gap_reg - PRE_ONE))
            |-> gap_reg == PCYC_X2_LAST + PRE_ONE;
    endproperty
    a_tick_x2: assert property (p_tick_x2) else $error("double-speed tick spacing wrong");
endmodule // dtc_prescaler

// ### dtc_timer_top.sv
// Dual 16-bit timer/counter with Wishbone register access
`timescale 1ns/1ps
module dtc_timer_top
(
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    // Wishbone slave
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [dtc_pkg::WB_ADR_W-1:0]   wb_adr_i,
    input  wire logic [dtc_pkg::WB_SEL_W-1:0]   wb_sel_i,
    input  wire logic [dtc_pkg::WB_DAT_W-1:0]   wb_dat_i,
    output logic      [dtc_pkg::WB_DAT_W-1:0]   wb_dat_o,
    output logic                                wb_ack_o,
    // External pins
    input  wire logic [1:0]                     count_pin,
    input  wire logic                           ext_irq0_pin_n,
    input  wire logic                           ext_irq1_pin_n,
    // Interrupt requests and service acknowledges
    input  wire logic [1:0]                     tmr_irq_ack,
    input  wire logic [1:0]                     ext_irq_ack,
    output logic      [1:0]                     tmr_irq,
    output logic      [1:0]                     ext_irq
);
    import dtc_pkg::*;

    logic [7:0]        timer_control_register;
    logic [7:0]        ctrl_next;
    logic [7:0]        timer_mode_register;
    logic              double_speed_mode;
    logic [1:0]        ext_pin_prev_reg;
    logic [IDX_W-1:0]  idx;
    logic              wr_stb;
    logic [7:0]        wr_byte;
    logic              pcyc_tick;
    logic [1:0]        run_bit;
    logic [1:0]        gate_pin;
    logic [1:0]        ext_pin_n;
    logic [1:0]        ovf_pulse;
    logic [1:0]        wr_low;
    logic [1:0]        wr_high;
    logic [7:0]        count_low_byte  [2];
    logic [7:0]        count_high_byte [2];
    logic [7:0]        rd_byte;

    function automatic logic [IDX_W-1:0] low_index(input int ch);
        low_index = (ch == 0) ? IDX_CNT0_LO : IDX_CNT1_LO;
    endfunction

    function automatic logic [IDX_W-1:0] high_index(input int ch);
        high_index = (ch == 0) ? IDX_CNT0_HI : IDX_CNT1_HI;
    endfunction

    function automatic int unsigned run_pos(input int ch);
        run_pos = (ch == 0) ? CTRL_RUN0 : CTRL_RUN1;
    endfunction

    function automatic int unsigned ovf_pos(input int ch);
        ovf_pos = (ch == 0) ? CTRL_OVF0 : CTRL_OVF1;
    endfunction

    function automatic int unsigned flag_pos(input int ch);
        flag_pos = (ch == 0) ? CTRL_IE0 : CTRL_IE1;
    endfunction

    function automatic int unsigned type_pos(input int ch);
        type_pos = (ch == 0) ? CTRL_IT0 : CTRL_IT1;
    endfunction

    assign idx       = wb_adr_i[IDX_LSB +: IDX_W];
    assign wr_byte   = wb_dat_i[7:0];
    // Writes land on the edge where ack is seen high, as the master expects
    assign wr_stb    = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign ext_pin_n = {ext_irq1_pin_n, ext_irq0_pin_n};
    // Counting gate follows the pin level: high lets the channel run
    assign gate_pin  = ext_pin_n;
    assign tmr_irq   = {timer_control_register[CTRL_OVF1], timer_control_register[CTRL_OVF0]};
    assign ext_irq   = {timer_control_register[CTRL_IE1], timer_control_register[CTRL_IE0]};

    // Wishbone: one wait state, ack for exactly one cycle, unmapped reads as zero
    always_ff @(posedge core_clk)
    begin
        if (rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    always_comb
    begin
        rd_byte = 8'h00;
        if (idx == IDX_CTRL)
            rd_byte = timer_control_register;
        else if (idx == IDX_MODE)
            rd_byte = timer_mode_register;
        else if (idx == IDX_CNT0_LO)
            rd_byte = count_low_byte[0];
        else if (idx == IDX_CNT1_LO)
            rd_byte = count_low_byte[1];
        else if (idx == IDX_CNT0_HI)
            rd_byte = count_high_byte[0];
        else if (idx == IDX_CNT1_HI)
            rd_byte = count_high_byte[1];
        else if (idx == IDX_SPEED)
            rd_byte = {7'h00, double_speed_mode};
    end

    // Counts may be read at any time; the byte is captured on the same edge that raises ack
    always_ff @(posedge core_clk)
    begin
        if (rst)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
            wb_dat_o <= {24'h00_0000, rd_byte};
    end

    // Mode register: gating, source select and mode field per channel
    always_ff @(posedge core_clk)
    begin
        if (rst)
            timer_mode_register <= MODE_RST;
        else if (wr_stb && idx == IDX_MODE)
            timer_mode_register <= wr_byte;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            double_speed_mode <= 1'b0;
        else if (wr_stb && idx == IDX_SPEED)
            double_speed_mode <= wr_byte[SPEED_X2];
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            ext_pin_prev_reg <= 2'b11;
        else
            ext_pin_prev_reg <= ext_pin_n;
    end

    // Control register: software write, then service clears, then hardware sets win
    always_comb
    begin
        ctrl_next = timer_control_register;
        if (wr_stb && idx == IDX_CTRL)
            ctrl_next = wr_byte;
        for (int ch = 0; ch < 2; ch++)
        begin
            if (tmr_irq_ack[ch])
                ctrl_next[ovf_pos(ch)] = 1'b0;
            if (ovf_pulse[ch])
                ctrl_next[ovf_pos(ch)] = 1'b1;
            if (timer_control_register[type_pos(ch)])
            begin
                if (ext_irq_ack[ch])
                    ctrl_next[flag_pos(ch)] = 1'b0;
                if (ext_pin_prev_reg[ch] && !ext_pin_n[ch])
                    ctrl_next[flag_pos(ch)] = 1'b1;
            end
            else
                ctrl_next[flag_pos(ch)] = !ext_pin_n[ch];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            timer_control_register <= CTRL_RST;
        else
            timer_control_register <= ctrl_next;
    end

    dtc_prescaler u_prescaler
    (
        .core_clk          (core_clk),
        .rst               (rst),
        .double_speed_mode (double_speed_mode),
        .pcyc_tick         (pcyc_tick)
    );

    // Both channels are the same logic; channel 1 takes the upper nibble and bits
    generate
        for (genvar ch = 0; ch < 2; ch++)
        begin : g_chan
            assign run_bit[ch] = timer_control_register[run_pos(ch)];
            assign wr_low[ch]  = wr_stb && (idx == low_index(ch));
            assign wr_high[ch] = wr_stb && (idx == high_index(ch));

            dtc_channel u_chan
            (
                .core_clk        (core_clk),
                .rst             (rst),
                .pcyc_tick       (pcyc_tick),
                .run_bit         (run_bit[ch]),
                .gating_enable   (timer_mode_register[ch*NIB_W + MODE_GATE]),
                .source_select   (timer_mode_register[ch*NIB_W + MODE_SRC]),
                .gate_pin        (gate_pin[ch]),
                .count_pin       (count_pin[ch]),
                .wr_low          (wr_low[ch]),
                .wr_high         (wr_high[ch]),
                .wr_data         (wr_byte),
                .count_low_byte  (count_low_byte[ch]),
                .count_high_byte (count_high_byte[ch]),
                .overflow_pulse  (ovf_pulse[ch])
            );
        end
    endgenerate

    property p_ack_single;
        @(posedge core_clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held longer than one cycle");

    property p_ack_timely;
        @(posedge core_clk) disable iff (rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_timely: assert property (p_ack_timely) else $error("request not acknowledged next cycle");

    property p_ovf_sets;
        @(posedge core_clk) disable iff (rst)
        ovf_pulse[0] |=> timer_control_register[CTRL_OVF0] && tmr_irq[0];
    endproperty
    a_ovf_sets: assert property (p_ovf_sets) else $error("channel 0 overflow flag not set");

    property p_ovf1_sets;
        @(posedge core_clk) disable iff (rst)
        ovf_pulse[1] |=> timer_control_register[CTRL_OVF1];
    endproperty
    a_ovf1_sets: assert property (p_ovf1_sets) else $error("channel 1 overflow flag not set");

    property p_ovf_clear;
        @(posedge core_clk) disable iff (rst)
        (timer_control_register[CTRL_OVF0] && tmr_irq_ack[0] && !ovf_pulse[0]
            && !(wr_stb && idx == IDX_CTRL)) |=> !timer_control_register[CTRL_OVF0];
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("serviced overflow flag not cleared");

    property p_level_flag;
        @(posedge core_clk) disable iff (rst)
        !timer_control_register[CTRL_IT0] ##1 !timer_control_register[CTRL_IT0]
            |-> timer_control_register[CTRL_IE0] == !$past(ext_irq0_pin_n);
    endproperty
    a_level_flag: assert property (p_level_flag) else $error("level interrupt flag wrong");

    property p_rollover_zero;
        @(posedge core_clk) disable iff (rst)
        ovf_pulse[0] |-> {count_high_byte[0], count_low_byte[0]} == 16'h0000 || $past(wr_low[0]);
    endproperty
    a_rollover_zero: assert property (p_rollover_zero) else $error("overflow without wrap to zero");
endmodule // dtc_timer_top

// ### dtc_timer_top_bench.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/1ps
module dtc_timer_top_bench;
    import dtc_pkg::*;
    logic        core_clk = 0;
    logic        rst      = 1;
    logic        wb_cyc   = 0;
    logic        wb_stb   = 0;
    logic        wb_we    = 0;
    logic [11:0] wb_adr   = '0;
    logic [3:0]  wb_sel   = '0;
    logic [31:0] wb_dat   = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [1:0]  count_pin;
    logic [1:0]  gate_n;
    logic [1:0]  tmr_ack  = '0;
    logic [1:0]  ext_ack  = '0;
    logic [1:0]  tmr_irq;
    logic [1:0]  ext_irq;
    int          miscompares = 0;
    int          checked     = 0;
    int          cyc_n       = 0;
    int          ack_at      = 0;
    logic [7:0]  q;

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) cyc_n <= cyc_n + 1;

    dtc_pin_model model_u (.core_clk(core_clk), .count_pin(count_pin), .gate_n(gate_n));

    dtc_timer_top dut_u
    (
        .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .count_pin(count_pin), .ext_irq0_pin_n(gate_n[0]),
        .ext_irq1_pin_n(gate_n[1]), .tmr_irq_ack(tmr_ack), .ext_irq_ack(ext_ack),
        .tmr_irq(tmr_irq), .ext_irq(ext_irq)
    );

    task automatic close_out();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Classic cycle; waits for ack with no assumed latency
    task automatic bus(input logic we, input logic [9:0] idx, input logic [7:0] d, output logic [7:0] r);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_sel <= 4'hf;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h0, d};
        do
        begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        r      = wb_dat_o[7:0];
        ack_at = cyc_n;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, idx, d, r);
    endtask

    task automatic rd(input logic [9:0] idx, output logic [7:0] r);
        bus(1'b0, idx, 8'h00, r);
    endtask

    // Run a channel for a measured span; per 0 means no counting is expected
    task automatic run_check(input int ch, input int per, input logic [15:0] pre);
        logic [7:0]  h;
        logic [7:0]  l;
        logic [15:0] d;
        logic        ok;
        int          t0;
        int          iv;
        wr(ch ? IDX_CNT1_LO : IDX_CNT0_LO, pre[7:0]);
        wr(ch ? IDX_CNT1_HI : IDX_CNT0_HI, pre[15:8]);
        wr(IDX_CTRL, ch ? 8'h40 : 8'h10);
        t0 = ack_at;
        repeat (94) @(posedge core_clk);
        wr(IDX_CTRL, 8'h00);
        iv = ack_at - t0;
        rd(ch ? IDX_CNT1_HI : IDX_CNT0_HI, h);
        rd(ch ? IDX_CNT1_LO : IDX_CNT0_LO, l);
        d  = {h, l} - pre;
        ok = (per == 0) ? (d == 0) : (d == iv / per || d == (iv + per - 1) / per);
        chk(16'(ok), 16'h0001);
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        close_out();
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(IDX_CNT0_LO, q); chk(16'(q), 16'h0000);
        rd(IDX_CNT0_HI, q); chk(16'(q), 16'h0000);
        rd(IDX_CNT1_HI, q); chk(16'(q), 16'h0000);
        rd(10'h3ff, q);     chk(16'(q), 16'h0000);
        // Gate pin low must not matter while gating is off
        model_u.set_gate(0, 1'b0);
        run_check(0, 12, 16'h12fc);
        wr(IDX_MODE, 8'h08);
        run_check(0, 0, 16'h0100);
        model_u.set_gate(0, 1'b1);
        run_check(0, 12, 16'h0100);
        model_u.set_gate(1, 1'b0);
        wr(IDX_MODE, 8'h80);
        run_check(1, 0, 16'h0000);
        model_u.set_gate(1, 1'b1);
        // Counter source: five falls, each level held one peripheral cycle
        for (int ch = 0; ch < 2; ch++)
        begin
            wr(IDX_MODE, ch ? 8'h40 : 8'h04);
            wr(ch ? IDX_CNT1_LO : IDX_CNT0_LO, 8'h00);
            wr(IDX_CTRL, ch ? 8'h40 : 8'h10);
            model_u.pulses(ch, 5, 12);
            wr(IDX_CTRL, 8'h00);
            rd(ch ? IDX_CNT1_LO : IDX_CNT0_LO, q);
            chk(16'(q), 16'h0005);
        end
        wr(IDX_MODE, 8'h00);
        // Rollover sets the flag; ack and a zero write clear it
        wr(IDX_CNT0_LO, 8'hfe);
        wr(IDX_CNT0_HI, 8'hff);
        wr(IDX_CTRL, 8'h10);
        for (int n = 0; n < 60 && tmr_irq[0] !== 1'b1; n++) @(posedge core_clk);
        chk(16'(tmr_irq), 16'h0001);
        rd(IDX_CTRL, q);    chk(16'(q), 16'h0030);
        wr(IDX_CTRL, 8'h20);
        rd(IDX_CNT0_HI, q); chk(16'(q), 16'h0000);
        tmr_ack <= 2'b01;
        @(posedge core_clk);
        tmr_ack <= 2'b00;
        @(posedge core_clk);
        @(posedge core_clk);
        chk(16'(tmr_irq), 16'h0000);
        wr(IDX_CTRL, 8'h20);
        chk(16'(tmr_irq), 16'h0001);
        wr(IDX_CTRL, 8'h00);
        @(posedge core_clk);
        chk(16'(tmr_irq), 16'h0000);
        // Edge-type external flag
        wr(IDX_CTRL, 8'h01);
        model_u.set_gate(0, 1'b0);
        repeat (3) @(posedge core_clk);
        chk(16'(ext_irq[0]), 16'h0001);
        rd(IDX_CTRL, q);    chk(16'(q), 16'h0003);
        model_u.set_gate(0, 1'b1);
        ext_ack <= 2'b01;
        @(posedge core_clk);
        ext_ack <= 2'b00;
        repeat (2) @(posedge core_clk);
        chk(16'(ext_irq[0]), 16'h0000);
        wr(IDX_CTRL, 8'h00);
        // Double speed halves the peripheral cycle
        wr(IDX_SPEED, 8'h01);
        run_check(1, 6, 16'h00f8);
        // Channel 1 rollover sets its own flag; its own service pulse clears it
        wr(IDX_CNT1_LO, 8'hff);
        wr(IDX_CNT1_HI, 8'hff);
        wr(IDX_CTRL, 8'h40);
        for (int n = 0; n < 60 && tmr_irq[1] !== 1'b1; n++) @(posedge core_clk);
        chk(16'(tmr_irq), 16'h0002);
        wr(IDX_CTRL, 8'h80);
        tmr_ack <= 2'b10;
        @(posedge core_clk);
        tmr_ack <= 2'b00;
        repeat (2) @(posedge core_clk);
        chk(16'(tmr_irq), 16'h0000);
        close_out();
    end
endmodule // dtc_timer_top_bench
